// file: rtl/ssdo_fifo.v
// parameterised valid/ready fifo for result words
`timescale 1ns/10ps
module ssdo_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // write side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // read side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  reg [AW:0]      nxt_count;
  reg             in_ready_ff;
  wire            do_wr;
  wire            do_rd;

  // honest full and empty from the fill count
  assign in_ready  = in_ready_ff;
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  // next fill count
  always @*
  begin
    nxt_count = count_ff;
    if (do_wr & ~do_rd)
      nxt_count = count_ff + 1'b1;
    else if (do_rd & ~do_wr)
      nxt_count = count_ff - 1'b1;
  end

  // storage array
  always @(posedge sys_clk)
  begin
    if (do_wr)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // pointers and count
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
      in_ready_ff <= 1'b1;
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != DEPTH[AW:0]); // registered so the ready pin comes from a flop
    end
  end
endmodule

// file: rtl/ssdo_regs.vh
// constants and timing counts for the serial daisy-chain output block
// Operation
// R1 - the chain input is used only while the shift clock comes from outside; internal clock mode keeps the output idle.
// R2 - the host drives the conversion strobe, chip select and shift clock in common to every device of a chain.
// R3 - a falling edge of the conversion strobe makes the device sample its analog input at that moment; the code samples only in external clock mode.
// R4 - the host starts the shift clock only after the conversion has finished.
// R5 - the most significant result bit appears after the rising edge of shift clock pulse one.
// R6 - the least significant result bit is shifted out on the rising edge of shift clock pulse sixteen.
// R7 - one filler bit follows the least significant bit before chain input bits are forwarded.
// R8 - the host gives at least thirty-four shift clock pulses to collect two chained results on falling edges.
// R9 - at the fastest shift clock the host reads two results after conversion and keeps the full sample rate.
// R10 - the last device of a two-device chain has its chain input and chip select held low.
// R11 - the format select input chooses straight binary when high and two's complement when low.
// R12 - each result goes out as a sixteen-bit word, most significant bit first.
// R13 - the clock source select input high makes the shift clock pin an input for the host's clock.
// R14 - after the least significant bit the output shifts out chain input levels, the first one sampled at pulse one.
// R15 - the host gives seventeen more shift clock pulses for every further chained device.
`ifndef SSDO_REGS_VH
`define SSDO_REGS_VH
`define SSDO_WORD_BITS     16
`define SSDO_CNT_BITS      5
`define SSDO_LSB_PULSE     5'h10
`define SSDO_FILL_PULSE    5'h11
`define SSDO_SIGN_FLIP     16'h8000
`define SSDO_CONV_TIME_NS  4000
`define SSDO_CLK_NS        100
`define SSDO_CONV_CYCLES   ((`SSDO_CONV_TIME_NS + `SSDO_CLK_NS - 1) / `SSDO_CLK_NS)
`define SSDO_CONV_LOAD     8'h27
`define SSDO_FIFO_DEPTH    8
`define SSDO_FIFO_AW       3
`endif

// file: rtl/ssdo_top.v
// serial result output with daisy-chain forwarding and format select
`timescale 1ns/10ps
`include "ssdo_regs.vh"
module ssdo_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // host strobes and pins (asynchronous)
  input  wire        conv_start_n,
  input  wire        chip_select_n,
  input  wire        external_shift_clock,
  input  wire        chain_in,
  input  wire        output_format_select,
  input  wire        clock_source_select,
  // converter core result stream
  input  wire [15:0] core_data,
  input  wire        core_valid,
  output wire        core_ready,
  // serial pins
  output reg         serial_data_out,
  output reg         serial_data_oe,
  output reg         sample_hold,
  output reg         busy_n
);
  // state codes
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_SHFT = 2'h2;

  // synchronisers: first stage read only by second
  reg [1:0] sync_conv_ff;
  reg [1:0] sync_cs_ff;
  reg [1:0] sync_sck_ff;
  reg [1:0] sync_chain_ff;
  reg [1:0] sync_fmt_ff;
  reg [1:0] sync_src_ff;
  reg       conv_d_ff;
  reg       sck_d_ff;

  // datapath state
  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [7:0]  conv_cnt_ff;
  reg [15:0] shift_ff;
  reg        rd_take;

  wire [15:0] fifo_data;
  wire        fifo_valid;
  wire        conv_fall;
  wire        sck_rise;
  wire        ext_mode;
  wire        cs_act;
  wire [15:0] fmt_word;

  // result words queue from the core
  ssdo_fifo #(
    .WIDTH (`SSDO_WORD_BITS),
    .DEPTH (`SSDO_FIFO_DEPTH),
    .AW    (`SSDO_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (core_data),
    .in_valid  (core_valid),
    .in_ready  (core_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (rd_take)
  );

  // two-flop synchronisers for every pin input
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync_conv_ff  <= 2'h3;
      sync_cs_ff    <= 2'h3;
      sync_sck_ff   <= 2'h0;
      sync_chain_ff <= 2'h0;
      sync_fmt_ff   <= 2'h0;
      sync_src_ff   <= 2'h0;
      conv_d_ff     <= 1'b1;
      sck_d_ff      <= 1'b0;
    end
    else
    begin
      sync_conv_ff  <= {sync_conv_ff[0], conv_start_n};
      sync_cs_ff    <= {sync_cs_ff[0], chip_select_n};
      sync_sck_ff   <= {sync_sck_ff[0], external_shift_clock};
      sync_chain_ff <= {sync_chain_ff[0], chain_in};
      sync_fmt_ff   <= {sync_fmt_ff[0], output_format_select};
      sync_src_ff   <= {sync_src_ff[0], clock_source_select};
      conv_d_ff     <= sync_conv_ff[1];
      sck_d_ff      <= sync_sck_ff[1];
    end
  end

  // edge detection on synchronised levels
  assign conv_fall = conv_d_ff & ~sync_conv_ff[1];
  assign sck_rise  = ~sck_d_ff & sync_sck_ff[1];
  assign ext_mode  = sync_src_ff[1];              // see R13
  assign cs_act    = ~sync_cs_ff[1];

  // straight binary when high, two's complement when low
  assign fmt_word = sync_fmt_ff[1] ? fifo_data : (fifo_data ^ `SSDO_SIGN_FLIP); // see R11

  // next state
  always @*
  begin
    nxt_state = state_ff;
    rd_take   = 1'b0;
    case (state_ff)
      ST_IDLE:
      begin
        if (conv_fall & ext_mode)                 // see R1
          nxt_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (conv_cnt_ff == 8'h00)
        begin
          nxt_state = ST_SHFT;
          rd_take   = fifo_valid;
        end
      end
      ST_SHFT:
      begin
        if (conv_fall | ~ext_mode)
          nxt_state = ext_mode ? ST_CONV : ST_IDLE;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // conversion timing, sample and busy
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_ff    <= ST_IDLE;
      conv_cnt_ff <= 8'h00;
      sample_hold <= 1'b0;
      busy_n      <= 1'b1;
    end
    else
    begin
      state_ff    <= nxt_state;
      sample_hold <= 1'b0;
      if ((state_ff != ST_CONV) && (nxt_state == ST_CONV))
      begin
        conv_cnt_ff <= `SSDO_CONV_LOAD;
        sample_hold <= 1'b1;                      // see R3
        busy_n      <= 1'b0;
      end
      else if (state_ff == ST_CONV)
      begin
        if (conv_cnt_ff != 8'h00)
          conv_cnt_ff <= conv_cnt_ff - 8'h01;
        else
          busy_n <= 1'b1;                         // see R4
      end
    end
  end

  // shift register: result bits first, chain input levels queued behind them
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      shift_ff        <= 16'h0000;
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
    end
    else
    begin
      serial_data_oe <= cs_act & ext_mode;
      // output keeps its level until pulse one, so data moves only with the shift clock
      if ((state_ff == ST_CONV) && (nxt_state == ST_SHFT))
        shift_ff <= fifo_valid ? fmt_word : 16'h0000;
      else if ((state_ff == ST_SHFT) && sck_rise && cs_act)
      begin
        // pulses one to sixteen give the result msb first
        serial_data_out <= shift_ff[15];                     // see R5 see R6 see R12
        // chain level at pulse one leaves on pulse seventeen: the filler, since the next device
        // has not yet shown its msb; its result then follows one pulse later
        shift_ff        <= {shift_ff[14:0], sync_chain_ff[1]}; // see R7 see R14
      end
    end
  end
endmodule

// file: test/ssdo_host.sv
// host model: strobe, chip select and shift clock
`timescale 1ns/10ps
module ssdo_host (
  // clock
  input wire   sys_clk,
  // converter pins
  input wire   busy_n,
  input wire   serial_data_out,
  // host outputs
  output logic conv_start_n,
  output logic chip_select_n,
  output logic external_shift_clock,
  output logic chain_in
);
  // seventeen pulses for each device of a two-device chain
  localparam int PULSES = 17 * 2;
  logic hang;
  // idle: deselected, shift clock still
  initial {conv_start_n, chip_select_n, external_shift_clock, chain_in, hang} = 5'h18;
  // strobe, wait for the result, then 34 pulses, bits taken before each next rise
  task automatic read_frame(input logic c, output logic [33:0] bits);
    int n;
    n = 0;
    chip_select_n = 1'b0;
    chain_in = c;
    conv_start_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    #2 conv_start_n = 1'b1;
    while (busy_n !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #2 n++;
    end
    hang |= (n >= 100);
    for (int i = PULSES - 1; i >= 0; i--)
    begin
      external_shift_clock = 1'b1;
      repeat (4) @(posedge sys_clk);
      #2 external_shift_clock = 1'b0;
      repeat (4) @(posedge sys_clk);
      #2 bits[i] = serial_data_out;
      if (i == 32) chain_in = ~c;
    end
    chip_select_n = 1'b1;
    // let an edge pass so the next frame's select is a fresh change
    @(posedge sys_clk);
    #2;
  endtask
endmodule

// file: test/ssdo_properties.sv
// port assertions for the serial daisy-chain output
`timescale 1ns/10ps
module ssdo_props (
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // host pins
  input wire        conv_start_n,
  input wire        chip_select_n,
  input wire        external_shift_clock,
  input wire        chain_in,
  input wire        output_format_select,
  input wire        clock_source_select,
  // core stream
  input wire [15:0] core_data,
  input wire        core_valid,
  input wire        core_ready,
  // serial pins
  input wire        serial_data_out,
  input wire        serial_data_oe,
  input wire        sample_hold,
  input wire        busy_n
);
  // every check runs on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_idle:
    assert property ($fell(rst) |-> !sample_hold && busy_n && !serial_data_oe) else $error("pins busy at reset");
  a_strobe_samples:
    assert property (clock_source_select && $fell(conv_start_n) |-> ##[2:4] sample_hold) else $error("no sample");
  a_hold_single:
    assert property (sample_hold |=> !sample_hold [*8]) else $error("sample pulse too long");
  a_busy_starts:
    assert property ($rose(sample_hold) |-> !busy_n) else $error("busy not raised");
  a_busy_length:
    assert property ($fell(busy_n) |-> !busy_n [*8] ##[30:33] busy_n) else $error("conversion length");
  a_int_idle:
    assert property (!clock_source_select [*6] |-> !serial_data_oe) else $error("driving in internal mode");
  a_cs_idle:
    assert property (chip_select_n [*6] |-> !serial_data_oe) else $error("driving while deselected");
  a_oe_on:
    assert property ((!chip_select_n && clock_source_select) [*6] |-> serial_data_oe) else $error("not driving");
  a_data_moves:
    assert property ($changed(serial_data_out) |-> $past(external_shift_clock, 3)) else $error("data moved alone");
  // main scenarios
  c_conv: cover property ($rose(busy_n));
  c_shift: cover property ($changed(serial_data_out));
  c_int: cover property (!clock_source_select);
endmodule
bind ssdo_top ssdo_props u_props (.*);

// file: test/tb.sv
// self-checking bench for the serial daisy-chain output
`timescale 1ns/10ps
module tb;
  logic        sys_clk, rst, output_format_select, clock_source_select, core_valid, core_ready;
  logic        conv_start_n, chip_select_n, external_shift_clock, chain_in;
  logic        serial_data_out, serial_data_oe, sample_hold, busy_n;
  logic [15:0] core_data, w;
  logic [31:0] seed = 32'hAF07;
  logic [33:0] bits, exp;
  logic [15:0] q[$];
  int          mismatches, checks;
  ssdo_top dut (.*);
  ssdo_host host (.*);
  // system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // xorshift source
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // compare and count
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    checks++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // closing report
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst, output_format_select, clock_source_select, core_valid, core_data} = 20'hE0000;
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    clock_source_select = 1'b0;
    repeat (8) @(posedge sys_clk);
    #2 check(34'(serial_data_oe), 34'h0);
    // internal mode: a strobed frame with the chain high must leave the output still
    host.read_frame(1'b1, bits);
    check(bits, 34'h0);
    check(34'(busy_n), 34'h1);
    clock_source_select = 1'b1;
    // fill the fifo until it refuses
    repeat (12)
    begin
      core_data = rnd();
      core_valid = 1'b1;
      if (core_ready === 1'b1) q.push_back(core_data);
      @(posedge sys_clk);
      #2;
    end
    core_valid = 1'b0;
    check(34'(q.size()), 34'h8);
    // drain one word per frame; the last frame finds it empty
    for (int k = 0; k < 9; k++)
    begin
      w = rnd();
      output_format_select = w[1] | (k == 8);
      exp = {(k < 8) ? q.pop_front() : 16'h0, w[0], w[0], {16{~w[0]}}};
      if (!output_format_select) exp[33] = ~exp[33];
      host.read_frame(w[0], bits);
      check(bits, exp);
      if (k == 0) check(34'(core_ready), 34'h1);
      if (host.hang)
      begin
        mismatches++;
        break;
      end
    end
    print_verdict();
  end
endmodule
